// file: mhrs_regs.vh
// Constants of the holding-register query interpreter.
`ifndef MHRS_REGS_VH
`define MHRS_REGS_VH

// ****************************************************************
// Function codes
// ****************************************************************
`define MHRS_FC_READ      8'h03
`define MHRS_FC_WRITE     8'h06
`define MHRS_FC_DIAG      8'h08
`define MHRS_FC_MULTI     8'h10
`define MHRS_EXC_FLAG     8'h80
`define MHRS_DIAG_SUB_OK  16'h0000

// ****************************************************************
// Exception and communication error codes
// ****************************************************************
`define MHRS_EXC_FUNC     8'h01
`define MHRS_EXC_ADDR     8'h02
`define MHRS_EXC_DATA     8'h03
`define MHRS_EXC_SLAVE    8'h04
`define MHRS_ERR_FUNC     8'h88
`define MHRS_ERR_USER     8'h89
`define MHRS_ERR_NVM      8'h8A
`define MHRS_ERR_DATA     8'h8C
`define MHRS_ERR_DISABLE  8'h8D

// ****************************************************************
// Ranges and lengths
// ****************************************************************
`define MHRS_ADDR_MAX     16'h1FFF
`define MHRS_ADDR_LIMIT   17'h02000
`define MHRS_COUNT_LIMIT  16'h0011
`define MHRS_READ_MAX     16'h0010
`define MHRS_FRAME_MAX    9'h100
`define MHRS_FRAME_MIN    9'h004
`define MHRS_QUERY_LEN    9'h008
`define MHRS_MULTI_HDR    9'h009
`define MHRS_BROADCAST    8'h00

// ****************************************************************
// Error check
// ****************************************************************
`define MHRS_CRC_PRESET   16'hFFFF
`define MHRS_CRC_POLY     16'hA001

`endif

// file: mhrs_slave.v
// Query checker and executor of a holding-register serial slave.
//
// Contract
// - Unsupported function code is not executed; exception 01h is returned.
// - Diagnosis with sub-function other than 00h gives exception 01h.
// - Register address outside 0000h..1FFFh gives exception 02h.
// - Start address plus count reaching 2000h gives 02h, no register access.
// - Register count zero or above 16 gives exception 03h.
// - Byte count not twice the register count gives exception 03h.
// - Frame length outside that allowed for the function gives 03h.
// - Invalid-data conditions record error code 8Ch with exception 03h.
// - Invalid function or address conditions record error code 88h.
// - User-port download, initialise or teach refuses with 04h, code 89h.
// - Internal busy or memory alarm refuses with 04h and code 8Ah.
// - Written value outside setting range gives 04h and code 8Ch.
// - Command execution disabled gives 04h and code 8Dh.
// - Read returns 16-bit registers, at most 16 per query.
// - Several registers are read in ascending address order from start.
// - Read reply echoes address and function, byte count, values high first.
// - Function 06h writes one 16-bit value to the given address.
// - Exception reply carries function plus 80h, one code byte, CRC.
// - CRC-16 preset FFFFh, LSB first, reflected polynomial A001h.
// - Framing, parity, CRC errors or frames over 256 bytes are dropped.
// - Broadcasts execute without reply; foreign addresses are ignored.
`default_nettype none
`include "mhrs_regs.vh"

module mhrs_slave
(
  input  wire        CLK_I,
  input  wire        RST_I,
  input  wire [7:0]  SLAVE_ADDR_I,
  input  wire        RX_VALID_I,
  input  wire [7:0]  RX_DATA_I,
  input  wire        RX_ERR_I,
  input  wire        RX_END_I,
  output wire        TX_VALID_O,
  output wire [7:0]  TX_DATA_O,
  input  wire        TX_READY_I,
  output wire        REG_RD_O,
  output wire        REG_WR_O,
  output wire [15:0] REG_ADDR_O,
  output wire [15:0] REG_WDATA_O,
  input  wire [15:0] REG_RDATA_I,
  input  wire        REG_ACK_I,
  input  wire        REG_RANGE_ERR_I,
  input  wire        REG_EXEC_DIS_I,
  input  wire        USER_PORT_BUSY_I,
  input  wire        INTERNAL_BUSY_FLAG_I,
  input  wire        NVM_ALARM_I,
  output wire        ERR_STB_O,
  output wire [7:0]  ERR_CODE_O
);

  localparam [4:0] ST_RX    = 5'h01;
  localparam [4:0] ST_CHECK = 5'h02;
  localparam [4:0] ST_RD    = 5'h04;
  localparam [4:0] ST_WR    = 5'h08;
  localparam [4:0] ST_TX    = 5'h10;

  localparam [1:0] RESP_EXC  = 2'h0;
  localparam [1:0] RESP_READ = 2'h1;
  localparam [1:0] RESP_ECHO = 2'h2;

  // ****************************************************************
  // CRC step
  // ****************************************************************
  // LSB-first reflected CRC.
  function [15:0] crc_step;
    input [15:0] crc;
    input [7:0]  data;
    integer      i;
    reg   [15:0] c;
    begin
      c = crc ^ {8'h00, data};
      for (i = 0; i < 8; i = i + 1)
      begin
        if (c[0])
          c = (c >> 1) ^ `MHRS_CRC_POLY;
        else
          c = c >> 1;
      end
      crc_step = c;
    end
  endfunction

  reg  [4:0]  state_q;
  reg  [7:0]  rxb_q [0:7];
  reg  [8:0]  rx_len_q;
  reg  [15:0] rx_crc_q;
  reg         rx_bad_q;
  reg  [15:0] rdm_q [0:15];
  reg  [3:0]  rd_idx_q;
  reg  [15:0] reg_addr_q;
  reg  [1:0]  resp_q;
  reg  [7:0]  exc_q;
  reg  [5:0]  tx_idx_q;
  reg  [5:0]  resp_len_q;
  reg  [15:0] tx_crc_q;
  reg  [7:0]  tx_data_q;
  reg         tx_valid_q;
  reg         err_stb_q;
  reg  [7:0]  err_code_q;

  wire [7:0]  fc       = rxb_q[1];
  wire [15:0] addr16   = {rxb_q[2], rxb_q[3]};
  wire [15:0] cnt16    = {rxb_q[4], rxb_q[5]};
  wire [16:0] addr_end = {1'b0, addr16} + {1'b0, cnt16};
  wire        is_multi = (fc == `MHRS_FC_READ) || (fc == `MHRS_FC_MULTI);
  wire        is_bcast = (rxb_q[0] == `MHRS_BROADCAST);
  wire [8:0]  exp_len  = (fc == `MHRS_FC_MULTI) ? (`MHRS_MULTI_HDR + {1'b0, rxb_q[6]})
                                                 : `MHRS_QUERY_LEN;

  // ****************************************************************
  // Query checks
  // ****************************************************************
  reg [7:0] chk_exc;
  reg [7:0] chk_err;
  always @*
  begin
    chk_exc = 8'h00;
    chk_err = 8'h00;
    if (!(is_multi || fc == `MHRS_FC_WRITE || fc == `MHRS_FC_DIAG))
    begin
      chk_exc = `MHRS_EXC_FUNC;
      chk_err = `MHRS_ERR_FUNC;
    end
    else if (fc == `MHRS_FC_DIAG && addr16 != `MHRS_DIAG_SUB_OK)
    begin
      chk_exc = `MHRS_EXC_FUNC;
      chk_err = `MHRS_ERR_FUNC;
    end
    else if (fc != `MHRS_FC_DIAG && addr16 > `MHRS_ADDR_MAX)
    begin
      chk_exc = `MHRS_EXC_ADDR;
      chk_err = `MHRS_ERR_FUNC;
    end
    else if (is_multi && addr_end >= `MHRS_ADDR_LIMIT)
    begin
      chk_exc = `MHRS_EXC_ADDR;
      chk_err = `MHRS_ERR_FUNC;
    end
    // Read is capped at sixteen registers.
    else if ((is_multi && (cnt16 == 16'h0000 || cnt16 > `MHRS_COUNT_LIMIT ||
                           cnt16 > `MHRS_READ_MAX)) ||
             (fc == `MHRS_FC_MULTI && {8'h00, rxb_q[6]} != {cnt16[14:0], 1'b0}) ||
             (rx_len_q != exp_len))
    begin
      chk_exc = `MHRS_EXC_DATA;
      chk_err = `MHRS_ERR_DATA;
    end
    else if (USER_PORT_BUSY_I)
    begin
      chk_exc = `MHRS_EXC_SLAVE;
      chk_err = `MHRS_ERR_USER;
    end
    else if (INTERNAL_BUSY_FLAG_I || NVM_ALARM_I)
    begin
      chk_exc = `MHRS_EXC_SLAVE;
      chk_err = `MHRS_ERR_NVM;
    end
    // Multi-register writes are validated only; execution is refused.
    else if (fc == `MHRS_FC_MULTI)
    begin
      chk_exc = `MHRS_EXC_SLAVE;
      chk_err = `MHRS_ERR_DISABLE;
    end
  end

  // Dropped frames get no reply and no error code.
  wire drop = rx_bad_q || (rx_crc_q != 16'h0000) || (rx_len_q > `MHRS_FRAME_MAX) ||
              (rx_len_q < `MHRS_FRAME_MIN) || (!is_bcast && rxb_q[0] != SLAVE_ADDR_I);

  // ****************************************************************
  // Reply bytes
  // ****************************************************************
  wire [5:0] nxt_idx = (state_q == ST_TX) ? (tx_idx_q + 6'h01) : 6'h00;
  wire [5:0] rd_off  = nxt_idx - 6'h03;
  reg  [7:0] nxt_byte;
  always @*
  begin
    nxt_byte = 8'h00;
    if (nxt_idx == 6'h00)
      nxt_byte = rxb_q[0];
    else if (resp_q == RESP_EXC)
      nxt_byte = (nxt_idx == 6'h01) ? (fc | `MHRS_EXC_FLAG) : exc_q;
    // Read reply: count, then each value high byte first.
    else if (resp_q == RESP_READ)
    begin
      if (nxt_idx == 6'h01)
        nxt_byte = fc;
      else if (nxt_idx == 6'h02)
        nxt_byte = {rxb_q[5][6:0], 1'b0};
      else if (rd_off[0])
        nxt_byte = rdm_q[rd_off[4:1]][7:0];
      else
        nxt_byte = rdm_q[rd_off[4:1]][15:8];
    end
    else
      nxt_byte = rxb_q[nxt_idx[2:0]];
  end

  wire [15:0] tx_crc_n = crc_step(tx_crc_q, tx_data_q);

  assign TX_VALID_O  = tx_valid_q;
  assign TX_DATA_O   = tx_data_q;
  assign REG_RD_O    = (state_q == ST_RD);
  assign REG_WR_O    = (state_q == ST_WR);
  assign REG_ADDR_O  = reg_addr_q;
  assign REG_WDATA_O = cnt16;
  assign ERR_STB_O   = err_stb_q;
  assign ERR_CODE_O  = err_code_q;

  // ****************************************************************
  // Sequencer
  // ****************************************************************
  integer k;
  always @(posedge CLK_I or posedge RST_I)
  begin
    if (RST_I)
    begin
      state_q    <= ST_RX;
      for (k = 0; k < 8; k = k + 1)
        rxb_q[k] <= 8'h00;
      for (k = 0; k < 16; k = k + 1)
        rdm_q[k] <= 16'h0000;
      rx_len_q   <= 9'h000;
      rx_crc_q   <= `MHRS_CRC_PRESET;
      rx_bad_q   <= 1'b0;
      rd_idx_q   <= 4'h0;
      reg_addr_q <= 16'h0000;
      resp_q     <= RESP_EXC;
      exc_q      <= 8'h00;
      tx_idx_q   <= 6'h00;
      resp_len_q <= 6'h00;
      tx_crc_q   <= `MHRS_CRC_PRESET;
      tx_data_q  <= 8'h00;
      tx_valid_q <= 1'b0;
      err_stb_q  <= 1'b0;
      err_code_q <= 8'h00;
    end
    else
    begin
      err_stb_q <= 1'b0;
      case (state_q)
        ST_RX:
        begin
          if (RX_VALID_I)
          begin
            if (rx_len_q < `MHRS_QUERY_LEN)
              rxb_q[rx_len_q[2:0]] <= RX_DATA_I;
            if (rx_len_q != 9'h1FF)
              rx_len_q <= rx_len_q + 9'h001;
            // Receive check runs over every byte, CRC included.
            rx_crc_q <= crc_step(rx_crc_q, RX_DATA_I);
          end
          if (RX_ERR_I)
            rx_bad_q <= 1'b1;
          if (RX_END_I)
            state_q <= ST_CHECK;
        end
        ST_CHECK:
        begin
          rx_len_q   <= 9'h000;
          rx_crc_q   <= `MHRS_CRC_PRESET;
          rx_bad_q   <= 1'b0;
          rd_idx_q   <= 4'h0;
          reg_addr_q <= addr16;
          if (drop)
            state_q <= ST_RX;
          else if (chk_exc != 8'h00)
          begin
            err_stb_q  <= 1'b1;
            err_code_q <= chk_err;
            exc_q      <= chk_exc;
            resp_q     <= RESP_EXC;
            resp_len_q <= 6'h03;
            state_q    <= is_bcast ? ST_RX : ST_TX;
            tx_valid_q <= !is_bcast;
            tx_data_q  <= nxt_byte;
            tx_idx_q   <= 6'h00;
            tx_crc_q   <= `MHRS_CRC_PRESET;
          end
          // Broadcast reads and diagnoses have nothing to execute.
          else if (fc == `MHRS_FC_WRITE)
            state_q <= ST_WR;
          else if (is_bcast)
            state_q <= ST_RX;
          else if (fc == `MHRS_FC_READ)
            state_q <= ST_RD;
          else
          begin
            resp_q     <= RESP_ECHO;
            resp_len_q <= 6'h06;
            state_q    <= ST_TX;
            tx_valid_q <= 1'b1;
            tx_data_q  <= nxt_byte;
            tx_idx_q   <= 6'h00;
            tx_crc_q   <= `MHRS_CRC_PRESET;
          end
        end
        ST_RD:
        begin
          if (REG_ACK_I)
          begin
            // Ascending addresses from the start address.
            rdm_q[rd_idx_q] <= REG_RDATA_I;
            reg_addr_q      <= reg_addr_q + 16'h0001;
            rd_idx_q        <= rd_idx_q + 4'h1;
            if ({12'h000, rd_idx_q} == cnt16 - 16'h0001)
            begin
              resp_q     <= RESP_READ;
              resp_len_q <= {rxb_q[5][4:0], 1'b0} + 6'h03;
              state_q    <= ST_TX;
              tx_valid_q <= 1'b1;
              tx_data_q  <= nxt_byte;
              tx_idx_q   <= 6'h00;
              tx_crc_q   <= `MHRS_CRC_PRESET;
            end
          end
        end
        ST_WR:
        begin
          if (REG_ACK_I)
          begin
            resp_q     <= RESP_ECHO;
            resp_len_q <= 6'h06;
            if (REG_RANGE_ERR_I)
            begin
              err_stb_q  <= 1'b1;
              err_code_q <= `MHRS_ERR_DATA;
              exc_q      <= `MHRS_EXC_SLAVE;
              resp_q     <= RESP_EXC;
              resp_len_q <= 6'h03;
            end
            else if (REG_EXEC_DIS_I)
            begin
              err_stb_q  <= 1'b1;
              err_code_q <= `MHRS_ERR_DISABLE;
              exc_q      <= `MHRS_EXC_SLAVE;
              resp_q     <= RESP_EXC;
              resp_len_q <= 6'h03;
            end
            state_q    <= is_bcast ? ST_RX : ST_TX;
            tx_valid_q <= !is_bcast;
            tx_data_q  <= rxb_q[0];
            tx_idx_q   <= 6'h00;
            tx_crc_q   <= `MHRS_CRC_PRESET;
          end
        end
        ST_TX:
        begin
          if (TX_READY_I)
          begin
            tx_idx_q <= tx_idx_q + 6'h01;
            if (tx_idx_q == resp_len_q + 6'h01)
            begin
              tx_valid_q <= 1'b0;
              state_q    <= ST_RX;
            end
            // Reply CRC goes out low byte first.
            else if (tx_idx_q == resp_len_q)
              tx_data_q <= tx_crc_q[15:8];
            else
            begin
              tx_crc_q <= tx_crc_n;
              if (nxt_idx == resp_len_q)
                tx_data_q <= tx_crc_n[7:0];
              else
                tx_data_q <= nxt_byte;
            end
          end
        end
        default:
          state_q <= ST_RX;
      endcase
    end
  end

endmodule
`default_nettype wire

// file: mhrs_slave_monitor.sv
// Concurrent checks on the ports of the query interpreter.
`default_nettype none
module mhrs_slave_monitor
(
  input wire logic        CLK_I,
  input wire logic        RST_I,
  input wire logic [7:0]  SLAVE_ADDR_I,
  input wire logic        TX_VALID_O,
  input wire logic [7:0]  TX_DATA_O,
  input wire logic        TX_READY_I,
  input wire logic        REG_RD_O,
  input wire logic        REG_WR_O,
  input wire logic [15:0] REG_ADDR_O,
  input wire logic [15:0] REG_WDATA_O,
  input wire logic        REG_ACK_I,
  input wire logic        ERR_STB_O,
  input wire logic [7:0]  ERR_CODE_O
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge CLK_I); endclocking
  default disable iff (RST_I);
  logic [5:0] idx_q;
  logic       exc_q;
  logic       rd_q;
  // ****************************************************************
  // Reply tracking
  // ****************************************************************
  // Position and kind of the reply byte on offer, so fields can be checked by place.
  always @(posedge CLK_I or posedge RST_I)
  begin
    if (RST_I)
      idx_q <= 6'h00;
    else if (!TX_VALID_O)
      idx_q <= 6'h00;
    else if (TX_READY_I)
      idx_q <= idx_q + 6'h01;
  end
  always @(posedge CLK_I)
  begin
    if (TX_VALID_O && TX_READY_I && idx_q == 6'h01)
    begin
      exc_q <= TX_DATA_O[7];
      rd_q  <= TX_DATA_O == 8'h03;
    end
  end
  sequence s_req_wait;
    (REG_RD_O || REG_WR_O) && !REG_ACK_I;
  endsequence
  sequence s_take;
    TX_VALID_O && TX_READY_I;
  endsequence
  AST_REQ_HOLD: assert property (s_req_wait |=> $stable({REG_RD_O, REG_WR_O})
    && $stable(REG_ADDR_O) && $stable(REG_WDATA_O)) else $error("register request not held");
  AST_TX_HOLD: assert property (TX_VALID_O && !TX_READY_I |=>
    TX_VALID_O && $stable(TX_DATA_O)) else $error("reply byte not held");
  AST_FIRST_ADDR: assert property ($rose(TX_VALID_O) |->
    TX_DATA_O == SLAVE_ADDR_I) else $error("reply does not start with own address");
  AST_EXC_CODE: assert property (TX_VALID_O && idx_q == 6'h02 && exc_q |->
    TX_DATA_O inside {[8'h01:8'h04]}) else $error("exception code out of set");
  AST_EXC_LEN: assert property (s_take ##0 (exc_q && idx_q == 6'h04) |=>
    !TX_VALID_O) else $error("exception reply longer than five bytes");
  AST_RD_COUNT: assert property (TX_VALID_O && idx_q == 6'h02 && rd_q && !exc_q |->
    !TX_DATA_O[0] && TX_DATA_O inside {[8'h02:8'h20]}) else $error("read byte count wrong");
  AST_ERR_PULSE: assert property (ERR_STB_O |=> !ERR_STB_O [*3])
    else $error("error strobe longer than one cycle");
  AST_ERR_CODE: assert property (ERR_STB_O |->
    ERR_CODE_O inside {8'h88, 8'h89, 8'h8A, 8'h8C, 8'h8D}) else $error("unknown error code");
  AST_ERR_HOLD: assert property (!ERR_STB_O |-> $stable(ERR_CODE_O))
    else $error("error code changed without strobe");
endmodule
bind mhrs_slave mhrs_slave_monitor u_mon
(
  .CLK_I(CLK_I), .RST_I(RST_I), .SLAVE_ADDR_I(SLAVE_ADDR_I), .TX_VALID_O(TX_VALID_O),
  .TX_DATA_O(TX_DATA_O), .TX_READY_I(TX_READY_I), .REG_RD_O(REG_RD_O), .REG_WR_O(REG_WR_O),
  .REG_ADDR_O(REG_ADDR_O), .REG_WDATA_O(REG_WDATA_O), .REG_ACK_I(REG_ACK_I),
  .ERR_STB_O(ERR_STB_O), .ERR_CODE_O(ERR_CODE_O)
);
`default_nettype wire

// file: mhrs_master.sv
// Line master model: sends checked query frames and takes reply bytes with stalls.
`default_nettype none
module mhrs_master
(
  input  wire logic       clk_i,
  output var  logic       rx_valid_o,
  output var  logic [7:0] rx_data_o,
  output var  logic       rx_err_o,
  output var  logic       rx_end_o,
  input  wire logic       tx_valid_i,
  input  wire logic [7:0] tx_data_i,
  output var  logic       tx_ready_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] fb[$];
  logic [7:0] rq[$];
  initial
  begin
    rx_valid_o = 1'b0;
    rx_data_o  = 8'h00;
    rx_err_o   = 1'b0;
    rx_end_o   = 1'b0;
    tx_ready_o = 1'b0;
  end
  function automatic logic [15:0] crc(input logic [7:0] b[$]);
    logic [15:0] c;
    c = 16'hFFFF;
    foreach (b[i])
    begin
      c = c ^ {8'h00, b[i]};
      repeat (8) c = c[0] ? (c >> 1) ^ 16'hA001 : c >> 1;
    end
    return c;
  endfunction
  task automatic send(input logic bad, input logic perr);
    logic [15:0] c;
    c = crc(fb) ^ {15'h0000, bad};
    fb.push_back(c[7:0]);
    fb.push_back(c[15:8]);
    foreach (fb[i])
    begin
      rx_valid_o <= 1'b1;
      rx_data_o  <= fb[i];
      rx_err_o   <= perr && i == 2;
      @(posedge clk_i);
    end
    // The data line is not held after a frame, so stale bytes cannot pass.
    rx_valid_o <= 1'b0;
    rx_data_o  <= ~rx_data_o;
    rx_err_o   <= 1'b0;
    rx_end_o   <= 1'b1;
    @(posedge clk_i);
    rx_end_o   <= 1'b0;
  endtask
  always @(posedge clk_i)
  begin
    if (tx_valid_i && tx_ready_o)
      rq.push_back(tx_data_i);
    tx_ready_o <= ($urandom % 4) != 0;
  end
endmodule
`default_nettype wire

// file: mhrs_slave_tb.sv
// Self-checking bench of the holding-register query interpreter.
`default_nettype none
module mhrs_slave_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic             CLK_I = 1'b0;
  logic             RST_I = 1'b1;
  logic [7:0]       own = 8'h00;
  logic [15:0]      rdata = 16'h0000;
  logic             ack = 1'b0;
  logic             rng = 1'b0;
  logic             dis = 1'b0;
  logic             upb = 1'b0;
  logic             ibusy = 1'b0;
  logic             nvm = 1'b0;
  logic [15:0]      wa, wd, r1, w;
  logic [7:0]       ecode;
  logic [7:0]       eq[$];
  wire logic        rxv, rxe, rxn, txv, txr, rd, wr, stb;
  wire logic [7:0]  rxd, txd, ecd;
  wire logic [15:0] ra, rw;
  int               fails = 0, n_compared = 0, nr = 0, nw = 0, nstb = 0, n;
  mhrs_master m (.clk_i(CLK_I), .rx_valid_o(rxv), .rx_data_o(rxd), .rx_err_o(rxe),
    .rx_end_o(rxn), .tx_valid_i(txv), .tx_data_i(txd), .tx_ready_o(txr));
  mhrs_slave dut (.CLK_I(CLK_I), .RST_I(RST_I), .SLAVE_ADDR_I(own), .RX_VALID_I(rxv),
    .RX_DATA_I(rxd), .RX_ERR_I(rxe), .RX_END_I(rxn), .TX_VALID_O(txv), .TX_DATA_O(txd),
    .TX_READY_I(txr), .REG_RD_O(rd), .REG_WR_O(wr), .REG_ADDR_O(ra), .REG_WDATA_O(rw),
    .REG_RDATA_I(rdata), .REG_ACK_I(ack), .REG_RANGE_ERR_I(rng), .REG_EXEC_DIS_I(dis),
    .USER_PORT_BUSY_I(upb), .INTERNAL_BUSY_FLAG_I(ibusy), .NVM_ALARM_I(nvm),
    .ERR_STB_O(stb), .ERR_CODE_O(ecd));
  always #5 CLK_I = ~CLK_I;
  function automatic logic [15:0] rv(input logic [15:0] a);
    return {a[7:0], a[15:8]} ^ 16'h5A3C;
  endfunction
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    n_compared++;
    if (g !== e)
    begin
      fails++;
      $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic tally_and_finish;
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // ****************************************************************
  // Register port
  // ****************************************************************
  // Answers after a random wait, as a slow parameter store would.
  always @(posedge CLK_I)
  begin
    if ((rd || wr) && !ack && $urandom % 2)
    begin
      ack   <= 1'b1;
      rdata <= rv(ra);
      nr    <= nr + rd;
      nw    <= nw + wr;
      wa    <= ra;
      wd    <= rw;
    end
    else
    begin
      ack   <= 1'b0;
      rdata <= ~rdata;
    end
    if (stb)
    begin
      nstb  <= nstb + 1;
      ecode <= ecd;
    end
  end
  // ****************************************************************
  // One query: fl is perr, bad check, range, disable, user, busy, alarm
  // ****************************************************************
  task automatic tq(input logic [7:0] a, f, input logic [15:0] w1, w2, input int nx,
                    input logic [6:0] fl, input logic [7:0] exc, ec, input int na);
    logic [15:0] c;
    int          k;
    int          b_rw, b_stb;
    m.fb = '{a, f, w1[15:8], w1[7:0], w2[15:8], w2[7:0]};
    for (k = 0; k < nx; k++)
      m.fb.push_back(k == 0 ? 8'(nx - 1) : 8'($urandom));
    if (exc !== 8'h00)
      eq = '{a, f | 8'h80, exc};
    else if (f == 8'h03)
    begin
      eq = '{a, f, {w2[6:0], 1'b0}};
      for (k = 0; k < w2; k++)
      begin
        c = rv(w1 + 16'(k));
        eq.push_back(c[15:8]);
        eq.push_back(c[7:0]);
      end
    end
    else
      eq = m.fb;
    c = m.crc(eq);
    eq.push_back(c[7:0]);
    eq.push_back(c[15:8]);
    if (a != own || fl[6:5] != 2'b00 || nx > 250)
      eq.delete();
    {nvm, ibusy, upb, dis, rng} <= {fl[0], fl[1], fl[2], fl[3], fl[4]};
    // The port counters belong to the responder process, so only their baselines are taken here.
    b_rw  = nr + nw;
    b_stb = nstb;
    m.rq.delete();
    m.send(fl[5], fl[6]);
    for (k = 0; k < 1000 && m.rq.size() < eq.size(); k++)
      @(posedge CLK_I);
    if (k < 1000)
    begin
      repeat (30) @(posedge CLK_I);
      chk(16'(m.rq.size()), 16'(eq.size()));
      foreach (eq[i])
        if (i < m.rq.size())
          chk({8'h00, m.rq[i]}, {8'h00, eq[i]});
      chk(16'(nstb - b_stb), 16'(exc != 8'h00));
      if (exc != 8'h00)
        chk({8'h00, ecode}, {8'h00, ec});
      chk(16'(nr + nw - b_rw), 16'(na));
    end
    else
    begin
      fails++;
      tally_and_finish();
    end
  endtask
  initial
  begin
    void'($urandom(32'h7378));
    own = 8'($urandom_range(1, 247));
    repeat (20) @(posedge CLK_I);
    RST_I <= 1'b0;
    @(posedge CLK_I);
    tq(own, 8'h03, 16'h0402, 16'h0004, 0, 7'h00, 8'h00, 8'h00, 4);
    tq(own, 8'h03, 16'h1FEF, 16'h0010, 0, 7'h00, 8'h00, 8'h00, 16);
    tq(own, 8'h03, 16'h1FF0, 16'h0010, 0, 7'h00, 8'h02, 8'h88, 0);
    tq(own, 8'h06, 16'h2000, 16'h0001, 0, 7'h00, 8'h02, 8'h88, 0);
    tq(own, 8'h03, 16'h0000, 16'h0000, 0, 7'h00, 8'h03, 8'h8C, 0);
    tq(own, 8'h03, 16'h0000, 16'h0011, 0, 7'h00, 8'h03, 8'h8C, 0);
    tq(own, 8'h03, 16'h2000, 16'h0000, 0, 7'h04, 8'h02, 8'h88, 0);
    tq(own, 8'h04, 16'h0000, 16'h0001, 0, 7'h04, 8'h01, 8'h88, 0);
    tq(own, 8'h08, 16'h0001, 16'h1234, 0, 7'h00, 8'h01, 8'h88, 0);
    tq(own, 8'h08, 16'h0000, 16'h1234, 0, 7'h00, 8'h00, 8'h00, 0);
    tq(own, 8'h10, 16'h0604, 16'h0001, 5, 7'h00, 8'h03, 8'h8C, 0);
    tq(own, 8'h10, 16'h0604, 16'h0001, 3, 7'h00, 8'h04, 8'h8D, 0);
    tq(own, 8'h03, 16'h0000, 16'h0001, 1, 7'h00, 8'h03, 8'h8C, 0);
    tq(own, 8'h03, 16'h0000, 16'h0001, 248, 7'h00, 8'h03, 8'h8C, 0);
    tq(own, 8'h03, 16'h0000, 16'h0001, 254, 7'h00, 8'h00, 8'h00, 0);
    tq(own, 8'h03, 16'h0000, 16'h0001, 0, 7'h04, 8'h04, 8'h89, 0);
    tq(own, 8'h03, 16'h0000, 16'h0001, 0, 7'h02, 8'h04, 8'h8A, 0);
    tq(own, 8'h06, 16'h0000, 16'h0001, 0, 7'h01, 8'h04, 8'h8A, 0);
    tq(own, 8'h06, 16'h024B, 16'h0050, 0, 7'h10, 8'h04, 8'h8C, 1);
    tq(own, 8'h06, 16'h024B, 16'h0050, 0, 7'h08, 8'h04, 8'h8D, 1);
    // Codes 01h, 11h, 21h, 31h and 41h all lie outside the served set.
    for (n = 0; n < 5; n++)
      tq(own, {n[3:0], 4'h1}, 16'h0000, 16'h0001, 0, 7'h00, 8'h01, 8'h88, 0);
    tq(own, 8'h03, 16'h0000, 16'h0001, 0, 7'h20, 8'h00, 8'h00, 0);
    tq(own, 8'h03, 16'h0000, 16'h0001, 0, 7'h40, 8'h00, 8'h00, 0);
    // The inverse of an address in 01h..F7h is never the broadcast address.
    tq(~own, 8'h06, 16'h0001, 16'h0002, 0, 7'h00, 8'h00, 8'h00, 0);
    tq(8'h00, 8'h06, 16'h0123, 16'h0456, 0, 7'h00, 8'h00, 8'h00, 1);
    chk(wd, 16'h0456);
    RST_I <= 1'b1;
    repeat (3) @(posedge CLK_I);
    chk(16'(ecd), 16'h0000);
    chk(16'(txv), 16'h0000);
    RST_I <= 1'b0;
    @(posedge CLK_I);
    repeat (20)
    begin
      r1 = 16'($urandom % 2 ? $urandom_range(16'h1FE8, 16'h1FFF) : $urandom_range(0, 16'h1FFF));
      n = $urandom_range(1, 16);
      w = 16'($urandom);
      if (r1 + n >= 16'h2000)
        tq(own, 8'h03, r1, 16'(n), 0, 7'h00, 8'h02, 8'h88, 0);
      else
        tq(own, 8'h03, r1, 16'(n), 0, 7'h00, 8'h00, 8'h00, n);
      tq(own, 8'h06, r1, w, 0, 7'h00, 8'h00, 8'h00, 1);
      chk(wa, r1);
      chk(wd, w);
    end
    tally_and_finish();
  end
endmodule
`default_nettype wire
